// ===== wdg_params.svh
`ifndef WDG_PARAMS_SVH
`define WDG_PARAMS_SVH

// register map, byte addresses on the avalon slave
`define WDG_ADDR_W          8
`define WDG_CTRL_OFS        8'h24
`define WDG_STAT_OFS        8'h28

// control register layout
`define WDG_ACT_BIT         7
`define WDG_TOP_BIT         6
`define WDG_CNT_W           7
`define WDG_CTRL_RST        8'h7f

// status register layout
`define WDG_STAT_ACT_BIT    0
`define WDG_STAT_PULSE_BIT  1
`define WDG_STAT_PIN_BIT    2
`define WDG_STAT_HWOPT_BIT  3
`define WDG_STAT_HALTOPT_BIT 4

// prescaler: 16384 oscillator cycles per decrement
`define WDG_PRESC_DIV       16384
`define WDG_PRESC_W         14
`define WDG_PHASE_SHIFT     6
`define WDG_PHASE_TB0       8'h3b
`define WDG_PHASE_TB1       8'h35
`define WDG_PHASE_TB2       8'h23
`define WDG_PHASE_TB3       8'h36

// reset pulse timing
`define WDG_CLK_MHZ         50
`define WDG_RST_PULSE_NS    500
`define WDG_RST_PULSE_CYC   ((`WDG_RST_PULSE_NS * `WDG_CLK_MHZ) / 1000)

`endif

// ===== wdg_pkg.sv
package wdg_pkg;
   typedef enum logic [1:0] {
      WDG_BUS_IDLE,
      WDG_BUS_ACK
   } wdg_bus_state_t;

   typedef logic [1:0] wdg_timebase_t;
endpackage

// ===== wdg_prescaler.sv
`timescale 1ns/1ps
`include "wdg_params.svh"

module wdg_prescaler #(
   parameter int PRESC_W = `WDG_PRESC_W
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire wdg_pkg::wdg_timebase_t timebase_select,
   output logic                       tick
);
   import wdg_pkg::*;

   logic [PRESC_W-1:0] presc_reg;
   logic [PRESC_W-1:0] presc_next;
   logic [PRESC_W-1:0] phase;
   logic [7:0]         phase_sel;
   logic               tick_reg;
   logic               tick_next;

   // free running; never restarted by software, so refresh timing jitters by one period
   always_comb begin
      case (timebase_select)
         2'h0:    phase_sel = `WDG_PHASE_TB0;
         2'h1:    phase_sel = `WDG_PHASE_TB1;
         2'h2:    phase_sel = `WDG_PHASE_TB2;
         default: phase_sel = `WDG_PHASE_TB3;
      endcase
      phase      = PRESC_W'({6'h0, phase_sel} << `WDG_PHASE_SHIFT); // [RULE_16]
      presc_next = presc_reg + PRESC_W'(1); // [RULE_01]
      tick_next  = (presc_reg == phase); // [RULE_15]
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         presc_reg <= '0;
         tick_reg  <= 1'b0;
      end else begin
         presc_reg <= presc_next;
         tick_reg  <= tick_next;
      end
   end

   assign tick = tick_reg;
endmodule

// ===== wdg_pulse.sv
`timescale 1ns/1ps
`include "wdg_params.svh"

module wdg_pulse #(
   parameter int LEN = `WDG_RST_PULSE_CYC
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic start,
   output logic      busy
);
   import wdg_pkg::*;

   localparam int CW = $clog2(LEN + 1);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;

   // retrigger restarts the full length
   always_comb begin
      cnt_next = cnt_reg;
      if (start) begin
         cnt_next = CW'(LEN); // [RULE_04]
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - CW'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign busy = (cnt_reg != '0);
endmodule

// ===== wdg_top.sv
// Functional notes
// [RULE_01] counter decrements every 16384 clock cycles
// [RULE_02] counter always runs, even when not armed
// [RULE_03] armed and 40h to 3Fh starts reset
// [RULE_04] reset pin held low about 500 ns
// [RULE_05] low six bits give 64-step timeout
// [RULE_06] software refreshes before top bit clears
// [RULE_07] software writes values between FFh and C0h
// [RULE_08] writes keep top bit set, else reset
// [RULE_09] any reset leaves watchdog disarmed
// [RULE_10] software cannot disarm; only reset clears
// [RULE_11] arm with top bit clear resets at once
// [RULE_12] halt while armed causes system reset
// [RULE_13] option strap forces permanent hardware watchdog
// [RULE_14] option strap selects halt reset behaviour
// [RULE_15] control write never resynchronises prescaler
// [RULE_16] prescaler phase follows timebase selection
// [RULE_17] bit 7 arm, bits 6:0 counter, reset 7Fh
// [RULE_18] write loads counter; read shows arm and count
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "wdg_params.svh"

module wdg_top #(
   parameter int PULSE_LEN = `WDG_RST_PULSE_CYC
) (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic [`WDG_ADDR_W-1:0]  avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [31:0]             avs_writedata,
   input  wire logic [3:0]              avs_byteenable,
   output logic      [31:0]             avs_readdata,
   output logic                         avs_waitrequest,
   input  wire wdg_pkg::wdg_timebase_t  timebase_select,
   input  wire logic                    hw_watchdog_opt,
   input  wire logic                    halt_reset_opt,
   input  wire logic                    halt_req,
   output logic                         halt_enter,
   input  wire logic                    reset_pin_i,
   output logic                         reset_pin_o,
   output logic                         reset_pin_oe_n
);
   import wdg_pkg::*;

   // option straps and the reset pin come from outside the clock domain
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic       hw_opt;
   logic       halt_opt;
   logic       pin_level;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
      end else begin
         sync1_reg <= {reset_pin_i, halt_reset_opt, hw_watchdog_opt};
         sync2_reg <= sync1_reg;
      end
   end

   assign hw_opt    = sync2_reg[0];
   assign halt_opt  = sync2_reg[1];
   assign pin_level = sync2_reg[2];

   // prescaler
   logic tick;

   wdg_prescaler #(
      .PRESC_W (`WDG_PRESC_W)
   ) u_presc (
      .clk             (clk),
      .rst             (rst),
      .timebase_select (timebase_select),
      .tick            (tick)
   );

   // avalon slave: one wait cycle, answer on the second edge
   wdg_bus_state_t bus_state_reg;
   wdg_bus_state_t bus_state_next;
   logic           req;
   logic           take;
   logic           ctrl_hit;
   logic           stat_hit;
   logic           ctrl_wr;
   logic [31:0]    rdata_reg;
   logic [31:0]    rdata_next;

   assign req      = avs_read | avs_write;
   assign take     = req && (bus_state_reg == WDG_BUS_ACK);
   assign ctrl_hit = (avs_address == `WDG_CTRL_OFS);
   assign stat_hit = (avs_address == `WDG_STAT_OFS);
   assign ctrl_wr  = take && avs_write && ctrl_hit && avs_byteenable[0];

   assign avs_waitrequest = req && (bus_state_reg != WDG_BUS_ACK);

   // watchdog core state
   logic [`WDG_CNT_W-1:0] cnt_reg;
   logic [`WDG_CNT_W-1:0] cnt_next;
   logic                  act_reg;
   logic                  act_next;
   logic                  armed_next;
   logic                  fire;
   logic                  halt_enter_reg;
   logic                  halt_enter_next;
   logic                  halt_fire;
   logic                  pulse_busy;
   logic [7:0]            wbyte;

   assign wbyte = avs_writedata[7:0];

   always_comb begin
      cnt_next        = cnt_reg;
      act_next        = act_reg;
      halt_enter_next = 1'b0;
      halt_fire       = 1'b0;
      if (ctrl_wr) begin
         cnt_next = wbyte[`WDG_CNT_W-1:0]; // [RULE_18]
         act_next = act_reg | wbyte[`WDG_ACT_BIT]; // [RULE_10] [RULE_17]
      end else if (tick) begin
         cnt_next = cnt_reg - `WDG_CNT_W'(1); // [RULE_01] [RULE_02] [RULE_05]
      end
      armed_next = act_next | hw_opt; // [RULE_13]
      if (halt_req) begin
         if ((act_reg | hw_opt) && halt_opt) begin
            halt_fire = 1'b1; // [RULE_12] [RULE_14]
         end else begin
            halt_enter_next = 1'b1;
         end
      end
      fire = (armed_next && cnt_reg[`WDG_TOP_BIT] && !cnt_next[`WDG_TOP_BIT]) // [RULE_03]
           || (ctrl_wr && armed_next && !wbyte[`WDG_TOP_BIT]) // [RULE_08] [RULE_11]
           || halt_fire;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg        <= `WDG_CNT_W'(`WDG_CTRL_RST); // [RULE_17]
         act_reg        <= 1'b0; // [RULE_09]
         halt_enter_reg <= 1'b0;
      end else begin
         cnt_reg        <= cnt_next;
         act_reg        <= act_next;
         halt_enter_reg <= halt_enter_next;
      end
   end

   assign halt_enter = halt_enter_reg;

   // reset pulse on the open-drain pin; the system reset that follows clears us
   wdg_pulse #(
      .LEN (PULSE_LEN)
   ) u_pulse (
      .clk   (clk),
      .rst   (rst),
      .start (fire),
      .busy  (pulse_busy)
   );

   assign reset_pin_o    = 1'b0;
   assign reset_pin_oe_n = ~pulse_busy; // [RULE_04]

   // bus state and read data
   always_comb begin
      bus_state_next = bus_state_reg;
      rdata_next     = rdata_reg;
      case (bus_state_reg)
         WDG_BUS_IDLE: begin
            if (req) begin
               bus_state_next = WDG_BUS_ACK;
               rdata_next     = 32'h0;
               if (avs_read && ctrl_hit) begin
                  rdata_next[7:0] = {act_reg, cnt_reg}; // [RULE_18]
               end else if (avs_read && stat_hit) begin
                  rdata_next[`WDG_STAT_ACT_BIT]     = act_reg | hw_opt;
                  rdata_next[`WDG_STAT_PULSE_BIT]   = pulse_busy;
                  rdata_next[`WDG_STAT_PIN_BIT]     = pin_level;
                  rdata_next[`WDG_STAT_HWOPT_BIT]   = hw_opt;
                  rdata_next[`WDG_STAT_HALTOPT_BIT] = halt_opt;
               end
            end
         end
         WDG_BUS_ACK: begin
            bus_state_next = WDG_BUS_IDLE;
         end
         default: begin
            bus_state_next = WDG_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_state_reg <= WDG_BUS_IDLE;
         rdata_reg     <= 32'h0;
      end else begin
         bus_state_reg <= bus_state_next;
         rdata_reg     <= rdata_next;
      end
   end

   assign avs_readdata = rdata_reg;
endmodule

// ===== wdg_assertions.sv
`timescale 1ns/1ps
`include "wdg_params.svh"

module wdg_chk #(
   parameter int PULSE_LEN = 25
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        hw_watchdog_opt,
   input wire logic        halt_reset_opt,
   input wire logic        halt_req,
   input wire logic        halt_enter,
   input wire logic        reset_pin_oe_n
);
   import wdg_pkg::*;
   logic [7:0] low_cnt_reg;
   logic [7:0] low_cnt_next;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // length of the current low run on the pin
   always_comb begin
      low_cnt_next = reset_pin_oe_n ? 8'h00 : low_cnt_reg + 8'h01;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_cnt_reg <= 8'h00;
      end else begin
         low_cnt_reg <= low_cnt_next;
      end
   end
   a_wait_write: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("write wait state wrong");
   a_wait_read: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read wait state wrong");
   a_wait_idle: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
      else $error("wait without request");
   a_read_upper: assert property (
      avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_pulse_len: assert property (
      $rose(reset_pin_oe_n) |-> low_cnt_reg == PULSE_LEN)
      else $error("reset pulse length wrong");
   a_halt_source: assert property (halt_enter |-> $past(halt_req))
      else $error("halt entry without request");
   // straps reach the core two edges late, and the synchroniser is cleared by reset
   a_halt_reset: assert property (
      halt_req && $past(halt_reset_opt, 2) && $past(hw_watchdog_opt, 2)
      && !$past(rst, 1) && !$past(rst, 2)
      |=> !reset_pin_oe_n && !halt_enter)
      else $error("armed halt not reset");
   a_halt_pass: assert property (
      halt_req && !$past(halt_reset_opt, 2) |=> halt_enter)
      else $error("halt not entered");
   a_soft_reset: assert property (
      avs_write && !avs_waitrequest
      && avs_address == `WDG_CTRL_OFS && avs_byteenable[0]
      && avs_writedata[7:6] == 2'h2 |=> !reset_pin_oe_n)
      else $error("software reset missing");
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
`include "wdg_params.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
   $display("unexpected %s exp %h got %h", n, e, a); end end

module testbench;
   import wdg_pkg::*;
   localparam int PL = 3;
   logic          clk;
   logic          rst;
   logic [7:0]    avs_address;
   logic          avs_read;
   logic          avs_write;
   logic [31:0]   avs_writedata;
   logic [3:0]    avs_byteenable;
   logic [31:0]   avs_readdata;
   logic          avs_waitrequest;
   wdg_timebase_t timebase_select;
   logic          hw_watchdog_opt;
   logic          halt_reset_opt;
   logic          halt_req;
   logic          halt_enter;
   logic          reset_pin_i;
   logic          reset_pin_o;
   logic          reset_pin_oe_n;
   logic [31:0]   q;
   int            miscompares = 0;
   int            cmp_count = 0;

   // open-drain reset pin with a pull-up
   assign reset_pin_i = reset_pin_oe_n ? 1'b1 : reset_pin_o;

   wdg_top #(
      .PULSE_LEN (PL)
   ) DUT (
      .clk             (clk),
      .rst             (rst),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .timebase_select (timebase_select),
      .hw_watchdog_opt (hw_watchdog_opt),
      .halt_reset_opt  (halt_reset_opt),
      .halt_req        (halt_req),
      .halt_enter      (halt_enter),
      .reset_pin_i     (reset_pin_i),
      .reset_pin_o     (reset_pin_o),
      .reset_pin_oe_n  (reset_pin_oe_n)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task test_done;
      if (miscompares == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // one bus access; request held until waitrequest seen low
   task acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= ~wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         miscompares++;
         test_done();
      end
      @(posedge clk);
   endtask

   task pulse(input int lim);
      int k;
      int n;
      for (k = 0; k < lim && reset_pin_oe_n !== 1'b0; k++) @(posedge clk);
      if (k == lim) begin
         miscompares++;
         test_done();
      end
      `CHK("pin drive", 1'b0, reset_pin_o)
      for (n = 0; reset_pin_oe_n === 1'b0 && n < 50; n++) @(posedge clk);
      `CHK("pulse", PL, n)
   endtask

   task rst_dut;
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task halt;
      halt_req <= 1'b1;
      @(posedge clk);
      halt_req <= 1'b0;
      @(posedge clk);
   endtask

   initial begin
      rst = 1'b1;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h1;
      timebase_select = 2'h0;
      hw_watchdog_opt = 1'b0;
      halt_reset_opt = 1'b0;
      halt_req = 1'b0;
      rst_dut();
      acc(0, `WDG_CTRL_OFS, 8'h00);
      `CHK("ctrl", 32'h7f, q)
      acc(0, 8'h30, 8'h00);
      `CHK("unmapped", 32'h0, q)
      timebase_select <= 2'h2;
      acc(1, `WDG_CTRL_OFS, 8'h3f);
      acc(0, `WDG_CTRL_OFS, 8'h00);
      `CHK("ctrl", 32'h3f, q)
      // one full prescaler period holds exactly one decrement
      repeat (16390) @(posedge clk);
      acc(0, `WDG_CTRL_OFS, 8'h00);
      `CHK("count", 32'h3e, q)
      `CHK("pin", 1'b1, reset_pin_oe_n)
      acc(1, `WDG_CTRL_OFS, 8'hc1);
      acc(1, `WDG_CTRL_OFS, 8'h41);
      acc(0, `WDG_CTRL_OFS, 8'h00);
      `CHK("ctrl", 32'hc1, q)
      pulse(33000);
      rst_dut();
      acc(0, `WDG_CTRL_OFS, 8'h00);
      `CHK("ctrl", 32'h7f, q)
      // tick phase 35*64 after reset: a control write just before it must not delay it
      repeat (2200) @(posedge clk);
      acc(1, `WDG_CTRL_OFS, 8'h7f);
      acc(0, `WDG_CTRL_OFS, 8'h00);
      `CHK("ctrl", 32'h7f, q)
      repeat (50) @(posedge clk);
      acc(0, `WDG_CTRL_OFS, 8'h00);
      `CHK("phase", 32'h7e, q)
      acc(1, `WDG_CTRL_OFS, 8'hbf);
      pulse(10);
      hw_watchdog_opt <= 1'b1;
      halt_reset_opt <= 1'b1;
      rst_dut();
      acc(0, `WDG_STAT_OFS, 8'h00);
      `CHK("status", 32'h1d, q)
      halt();
      pulse(10);
      halt_reset_opt <= 1'b0;
      rst_dut();
      halt();
      `CHK("halt", 1'b1, halt_enter)
      test_done();
   end
endmodule

bind wdg_top wdg_chk #(
   .PULSE_LEN (PULSE_LEN)
) u_chk (
   .clk             (clk),
   .rst             (rst),
   .avs_address     (avs_address),
   .avs_read        (avs_read),
   .avs_write       (avs_write),
   .avs_writedata   (avs_writedata),
   .avs_byteenable  (avs_byteenable),
   .avs_readdata    (avs_readdata),
   .avs_waitrequest (avs_waitrequest),
   .hw_watchdog_opt (hw_watchdog_opt),
   .halt_reset_opt  (halt_reset_opt),
   .halt_req        (halt_req),
   .halt_enter      (halt_enter),
   .reset_pin_oe_n  (reset_pin_oe_n)
);
